/* core/ms_tick_gen.sv */
// millisecond enable pulse generator
// assumes clear is a same-clock pulse that restarts the period
`timescale 1ns/1ps
`default_nettype none
module ms_tick_gen
    import packer_pkg::*;
#(
    parameter int unsigned CYCLES = MS_CYCLES_DEF
) (
    // clock and reset
    input  wire logic mclk,
    input  wire logic sys_rst,
    // control
    input  wire logic clear,
    output logic      tick
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } tick_regs_t;

    tick_regs_t t_reg;
    tick_regs_t t_next;

    always_comb begin
        t_next      = t_reg;
        t_next.cnt  = t_reg.cnt + 16'h0001;
        t_next.tick = 1'b0;
        if (clear) begin
            t_next.cnt = 16'h0000;
        end else if (t_reg.cnt == 16'(CYCLES - 1)) begin
            t_next.cnt  = 16'h0000;
            t_next.tick = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            t_reg <= '0;
        end else begin
            t_reg <= t_next;
        end
    end

    assign tick = t_reg.tick;

endmodule
`default_nettype wire

/* core/packer_pkg.sv */
// shared types and constants of the serial-to-network packer
// assumes a single 25 MHz clock and byte-wide serial input
package packer_pkg;

    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned TICK_MS       = 1;
    localparam int unsigned MS_CYCLES_DEF = CLK_HZ / 1000 * TICK_MS;

    // ----------------------------------------
    // sizes and reset values
    // ----------------------------------------
    localparam int unsigned BUF_BYTES           = 1024;
    localparam logic [10:0] BUF_LAST_IDX        = 11'h3ff;
    localparam logic [15:0] LISTEN_PORT_DEFAULT = 16'h0fa1;
    localparam logic [7:0]  DELIM_UNUSED        = 8'h00;
    localparam logic [15:0] FORCE_OFF           = 16'h0000;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [1:0] {
        ST_FILL  = 2'b01,
        ST_DRAIN = 2'b10
    } pack_state_t;

    typedef struct packed {
        logic [7:0] data;
        logic       last;
    } frame_beat_t;

    typedef struct packed {
        logic [7:0]  delim1;
        logic [7:0]  delim2;
        logic [15:0] force_ms;
        logic        start_on_char;
        logic [15:0] listen_port;
    } packer_cfg_t;

    typedef struct packed {
        pack_state_t st;
        logic [10:0] fill_cnt;
        logic [10:0] rd_cnt;
        logic [15:0] idle_ms;
        logic        last_was_d1;
        logic        connect;
        logic        out_valid;
        frame_beat_t out_beat;
        logic        rx_ready;
        logic        udp_hit;
    } packer_regs_t;

endpackage

/* core/serial_to_network_data_packer.sv */
// serial byte packer: buffers serial bytes and emits network frames
// assumes serial bytes and network side share mclk; config held steady
//
// Overview of operation
// R01 - startup policy: connection attempt begins right after reset
// R02 - first-character policy: connection attempt starts on first serial byte
// R03 - both delimiters zero: every byte is sent at once as its own frame
// R04 - delimiter set: buffer until delimiter byte or pair, then send frame
// R05 - delimiters are 8-bit, zero unused; single uses first, both zero disables
// R06 - buffer full at 1K bytes: send frame and empty buffer
// R07 - force time 1..65535 ms: idle gap that long closes the frame
// R08 - force time zero: no idle timeout at all
// R09 - configurer must not enable second delimiter without the first
// R10 - configurer should set force time above one character time
// R11 - datagrams accepted on local listen port, default 4001
// R12 - idle timer restarts on each byte and clears on every frame close
`timescale 1ns/1ps
`default_nettype none
module serial_to_network_data_packer
    import packer_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_CYCLES_DEF
) (
    // clock and reset
    input  wire logic         mclk,
    input  wire logic         sys_rst,
    // configuration
    input  wire packer_cfg_t  cfg,
    // serial byte input
    input  wire logic         rx_valid,
    input  wire logic [7:0]   rx_data,
    output logic              rx_ready,
    // frame output to network
    output logic              tx_valid,
    output frame_beat_t       tx_beat,
    input  wire logic         tx_ready,
    // connection start
    output logic              tcp_connect,
    // datagram port match
    input  wire logic         udp_valid,
    input  wire logic [15:0]  udp_dst_port,
    output logic              udp_accept
);

    // ----------------------------------------
    // state and buffer
    // ----------------------------------------
    packer_regs_t r_reg;
    packer_regs_t r_next;
    logic [7:0]   buf_mem [BUF_BYTES];
    logic         ms_tick;
    logic         accept;
    logic         close_on_byte;
    logic         idle_close;
    logic [10:0]  cnt_inc;
    logic [15:0]  idle_inc;
    logic [15:0]  eff_port;
    logic         delim_none;

    assign accept     = rx_valid && r_reg.rx_ready && (r_reg.st == ST_FILL);
    assign cnt_inc    = r_reg.fill_cnt + 11'h001;
    assign idle_inc   = r_reg.idle_ms + 16'h0001;
    assign delim_none = (cfg.delim1 == DELIM_UNUSED) && (cfg.delim2 == DELIM_UNUSED); // R05
    assign eff_port   = (cfg.listen_port == 16'h0000) ? LISTEN_PORT_DEFAULT : cfg.listen_port; // R11

    // ----------------------------------------
    // millisecond base
    // ----------------------------------------
    ms_tick_gen #(
        .CYCLES (MS_CYCLES)
    ) u_ms_tick (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .clear   (accept),
        .tick    (ms_tick)
    );

    // ----------------------------------------
    // frame close decisions
    // ----------------------------------------
    always_comb begin
        close_on_byte = 1'b0;
        if (delim_none) begin
            close_on_byte = 1'b1; // R03
        end else if (cfg.delim2 == DELIM_UNUSED) begin
            close_on_byte = (rx_data == cfg.delim1); // R04
        end else begin
            close_on_byte = r_reg.last_was_d1 && (rx_data == cfg.delim2); // R04 R09
        end
        if (r_reg.fill_cnt == BUF_LAST_IDX) begin
            close_on_byte = 1'b1; // R06
        end
    end

    assign idle_close = (cfg.force_ms != FORCE_OFF) && ms_tick && (r_reg.fill_cnt != 11'h000)
                        && (idle_inc == cfg.force_ms); // R07 R08 R10

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        r_next         = r_reg;
        r_next.udp_hit = udp_valid && (udp_dst_port == eff_port); // R11
        r_next.connect = r_reg.connect || !cfg.start_on_char || accept; // R01 R02
        case (r_reg.st)
            ST_FILL: begin
                if (accept) begin
                    r_next.fill_cnt    = cnt_inc;
                    r_next.idle_ms     = 16'h0000; // R12
                    r_next.last_was_d1 = (rx_data == cfg.delim1);
                    if (close_on_byte) begin
                        r_next.st          = ST_DRAIN;
                        r_next.rx_ready    = 1'b0;
                        r_next.rd_cnt      = 11'h000;
                        r_next.last_was_d1 = 1'b0;
                    end
                end else if (idle_close) begin
                    r_next.st          = ST_DRAIN; // R07
                    r_next.rx_ready    = 1'b0;
                    r_next.rd_cnt      = 11'h000;
                    r_next.idle_ms     = 16'h0000; // R12
                    r_next.last_was_d1 = 1'b0;
                end else if (ms_tick && (cfg.force_ms != FORCE_OFF) && (r_reg.fill_cnt != 11'h000)) begin
                    r_next.idle_ms = idle_inc;
                end
            end
            ST_DRAIN: begin
                if (!r_reg.out_valid || tx_ready) begin
                    if (r_reg.rd_cnt < r_reg.fill_cnt) begin
                        r_next.out_valid     = 1'b1;
                        r_next.out_beat.data = buf_mem[r_reg.rd_cnt[9:0]];
                        r_next.out_beat.last = ((r_reg.rd_cnt + 11'h001) == r_reg.fill_cnt);
                        r_next.rd_cnt        = r_reg.rd_cnt + 11'h001;
                    end else begin
                        r_next.out_valid = 1'b0;
                        r_next.st        = ST_FILL; // R06
                        r_next.fill_cnt  = 11'h000;
                        r_next.rd_cnt    = 11'h000;
                        r_next.rx_ready  = 1'b1;
                    end
                end
            end
            default: begin
                r_next.st       = ST_FILL;
                r_next.fill_cnt = 11'h000;
                r_next.rx_ready = 1'b1;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            r_reg          <= '0;
            r_reg.st       <= ST_FILL;
            r_reg.rx_ready <= 1'b1;
        end else begin
            r_reg <= r_next;
        end
    end

    always_ff @(posedge mclk) begin
        if (accept) begin
            buf_mem[r_reg.fill_cnt[9:0]] <= rx_data; // R04
        end
    end

    assign rx_ready    = r_reg.rx_ready;
    assign tx_valid    = r_reg.out_valid;
    assign tx_beat     = r_reg.out_beat;
    assign tcp_connect = r_reg.connect;
    assign udp_accept  = r_reg.udp_hit;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    sequence s_drain_first;
        !rx_ready ##1 tx_valid;
    endsequence

    property p_connect_startup;
        !cfg.start_on_char |=> tcp_connect;
    endproperty
    a_connect_startup: assert property (p_connect_startup) else $error("startup policy did not connect"); // R01

    property p_connect_first_char;
        accept |=> tcp_connect;
    endproperty
    a_connect_first_char: assert property (p_connect_first_char) else $error("byte did not start connect"); // R02

    property p_wait_char;
        cfg.start_on_char && !tcp_connect && !accept |=> !tcp_connect;
    endproperty
    a_wait_char: assert property (p_wait_char) else $error("connect began without a byte"); // R02

    property p_immediate;
        accept && delim_none && r_reg.fill_cnt == 11'h000 |=> s_drain_first ##0 tx_beat.last;
    endproperty
    a_immediate: assert property (p_immediate) else $error("byte not sent at once"); // R03

    property p_single_delim;
        accept && cfg.delim1 != 8'h00 && cfg.delim2 == 8'h00 && rx_data == cfg.delim1 |=> r_reg.st == ST_DRAIN;
    endproperty
    a_single_delim: assert property (p_single_delim) else $error("delimiter did not close frame"); // R04

    property p_hold;
        accept && !delim_none && !close_on_byte |=> rx_ready && r_reg.st == ST_FILL;
    endproperty
    a_hold: assert property (p_hold) else $error("frame closed without cause"); // R05

    property p_full;
        accept && r_reg.fill_cnt == BUF_LAST_IDX |=> !rx_ready ##[1:3] tx_valid;
    endproperty
    a_full: assert property (p_full) else $error("full buffer not sent"); // R06

    property p_idle_bound;
        r_reg.st == ST_FILL && cfg.force_ms != 16'h0000 |-> r_reg.idle_ms < cfg.force_ms;
    endproperty
    a_idle_bound: assert property (p_idle_bound) else $error("idle time overran force time"); // R07

    property p_no_timeout;
        cfg.force_ms == 16'h0000 && r_reg.st == ST_FILL && !rx_valid |=> r_reg.st == ST_FILL;
    endproperty
    a_no_timeout: assert property (p_no_timeout) else $error("frame closed with timeout off"); // R08

    property p_listen;
        udp_valid && udp_dst_port == eff_port |=> udp_accept;
    endproperty
    a_listen: assert property (p_listen) else $error("datagram on listen port refused"); // R11

    property p_idle_restart;
        accept |=> r_reg.idle_ms == 16'h0000;
    endproperty
    a_idle_restart: assert property (p_idle_restart) else $error("idle timer not restarted"); // R12

endmodule
`default_nettype wire

/* testbench/net_sink.sv */
// network-side sink model for packer frame beats
// assumes beats change only after mclk rising edges
`timescale 1ns/1ps
`default_nettype none
module net_sink (
    // clock
    input  wire logic mclk,
    // control and handshake
    input  wire logic stall_en,
    output logic      tx_ready
);
    int seed = 32'h82c69021;
    initial tx_ready = 1'b1;
    // random stalls when enabled
    always @(posedge mclk) begin
        #1 tx_ready = !stall_en || ($random(seed) % 4 != 0);
    end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench for the serial-to-network packer
// assumes net_sink on the frame side and MS_CYCLES shortened
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end
module tb_top import packer_pkg::*; ;
    localparam int MSC = 10;
    logic        mclk = 1'b0, sys_rst = 1'b1, rx_valid = 1'b0, udp_valid = 1'b0, stall_en = 1'b0;
    logic [7:0]  rx_data = 8'h00, d1, x;
    logic [15:0] udp_dst_port = 16'h0000, p;
    packer_cfg_t cfg = '0;
    logic        rx_ready, tx_valid, tx_ready, tcp_connect, udp_accept;
    frame_beat_t tx_beat;
    int          err_count = 0, cmp_count = 0, seed = 32'h82c69021;
    logic [7:0]  exp_q[$], got_q[$];
    logic        lst_q[$];

    serial_to_network_data_packer #(.MS_CYCLES(MSC)) u_serial_to_network_data_packer (
        .mclk(mclk), .sys_rst(sys_rst), .cfg(cfg), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_beat(tx_beat), .tx_ready(tx_ready),
        .tcp_connect(tcp_connect), .udp_valid(udp_valid), .udp_dst_port(udp_dst_port),
        .udp_accept(udp_accept));
    net_sink u_net_sink (.mclk(mclk), .stall_en(stall_en), .tx_ready(tx_ready));

    always #20 mclk = ~mclk;
    always @(posedge mclk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got_q.push_back(tx_beat.data);
            lst_q.push_back(tx_beat.last);
        end
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic end_of_test();
        if (err_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic rst();
        sys_rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1 sys_rst = 1'b0;
        @(posedge mclk);
        #1;
    endtask
    function automatic logic [7:0] nd();
        logic [7:0] r;
        do r = 8'($random(seed)); while (r == cfg.delim1 || r == cfg.delim2);
        return r;
    endfunction
    task automatic send(input logic [7:0] b, input bit more);
        int n = 0;
        rx_valid = 1'b1;
        rx_data = b;
        while (rx_ready !== 1'b1 && n < 3000) begin
            @(posedge mclk);
            #1 n++;
        end
        if (n == 3000) begin
            err_count++;
            end_of_test();
        end
        exp_q.push_back(b);
        @(posedge mclk);
        #1;
        if (!more) rx_valid = 1'b0;
    endtask
    task automatic frame_chk();
        int n = 0;
        while (!(lst_q.size() > 0 && lst_q[$] === 1'b1) && n < 5000) begin
            @(posedge mclk);
            #1 n++;
        end
        if (n == 5000) begin
            err_count++;
            end_of_test();
        end
        `CHK("frame length", exp_q.size(), got_q.size())
        foreach (exp_q[i]) begin
            `CHK("frame byte", exp_q[i], got_q[i])
            `CHK("last flag", (i == exp_q.size() - 1), lst_q[i])
        end
        exp_q.delete();
        got_q.delete();
        lst_q.delete();
    endtask
    task automatic udp(input logic [15:0] port, input logic e);
        udp_valid = 1'b1;
        udp_dst_port = port;
        @(posedge mclk);
        #1 `CHK("udp accept", e, udp_accept)
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        rst();
        `CHK("connect at startup", 1'b1, tcp_connect)
        cfg.start_on_char = 1'b1;
        rst();
        repeat (5) @(posedge mclk);
        #1 `CHK("connect idle", 1'b0, tcp_connect)
        for (int k = 0; k < 4; k++) begin
            send(8'($random(seed)), 1'b0);
            frame_chk();
        end
        `CHK("connect on char", 1'b1, tcp_connect)
        stall_en = 1'b1;
        d1 = 8'($random(seed)) | 8'h01;
        cfg.delim1 = d1;
        for (int k = 0; k < 4; k++) begin
            repeat (k) send(nd(), 1'b1);
            send(d1, 1'b0);
            frame_chk();
        end
        cfg.delim2 = d1 ^ 8'h5a;
        x = nd();
        send(x, 1'b1);
        send(d1, 1'b1);
        send(x, 1'b1);
        send(d1, 1'b1);
        send(cfg.delim2, 1'b0);
        frame_chk();
        cfg.delim2 = 8'h00;
        cfg.force_ms = 16'h0002;
        send(nd(), 1'b0);
        repeat (15) @(posedge mclk);
        #1 `CHK("early close", 0, got_q.size())
        `CHK("fill after byte", 1'b1, rx_ready)
        send(nd(), 1'b0);
        repeat (15) @(posedge mclk);
        #1 `CHK("timer restart", 0, got_q.size())
        `CHK("fill after restart", 1'b1, rx_ready)
        repeat (8) @(posedge mclk);
        #1 `CHK("idle close", 1'b1, (got_q.size() > 0 || rx_ready === 1'b0))
        frame_chk();
        cfg.force_ms = FORCE_OFF;
        send(nd(), 1'b1);
        send(nd(), 1'b0);
        repeat (100) @(posedge mclk);
        #1 `CHK("no timeout", 0, got_q.size())
        send(d1, 1'b0);
        frame_chk();
        for (int i = 0; i < BUF_BYTES; i++)
            send(nd(), i < BUF_BYTES - 1);
        frame_chk();
        cfg.listen_port = 16'h0000;
        udp(LISTEN_PORT_DEFAULT, 1'b1);
        p = 16'($random(seed)) | 16'h0001;
        cfg.listen_port = p;
        udp(p, 1'b1);
        udp(p ^ 16'h0100, 1'b0);
        udp(LISTEN_PORT_DEFAULT, p == LISTEN_PORT_DEFAULT);
        udp_valid = 1'b0;
        end_of_test();
    end
endmodule
`undef CHK
`default_nettype wire
